// [common/flash_host_cfg.svh]
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

// Flash pin widths
`define FLASH_AW 24
`define FLASH_DW 16

// Clock and flash bus timing
`define CLK_PERIOD_NS 8
`define T_ACCESS_NS 75
`define T_RECOVER_NS 25
`define ACC_CYC ((`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REC_CYC ((`T_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Flash command codes
`define CMD_PROGRAM 16'h0040
`define CMD_ERASE_SETUP 16'h0020
`define CMD_CONFIRM 16'h00D0
`define CMD_CLEAR_STATUS 16'h0050
`define CMD_READ_ARRAY 16'h00FF
`define CMD_READ_STATUS 16'h0070
`define CMD_QUERY 16'h0098
`define CMD_BUF_SETUP 16'h00E8

// Flash status word bits
`define SR_READY_BIT 7
`define SR_PROG_FAIL_BIT 4
`define SR_VOLT_BIT 3
`define SR_LOCK_BIT 1

// Wishbone register byte offsets
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_DATA 8'h08
`define REG_STATUS 8'h0C
`define REG_RDATA 8'h10

// Control register field
`define CTRL_OP_LSB 0
`define CTRL_OP_MSB 3

// Host status register fields
`define ST_BUSY_BIT 0
`define ST_REFUSED_BIT 1
`define ST_ERR_BIT 2
`define ST_BUFPEND_BIT 3
`define ST_SR_LSB 8
`define ST_SR_MSB 15

`endif

// [common/flash_host_pkg.sv]
package flash_host_pkg;
`include "flash_host_cfg.svh"

    // Flash and Wishbone side scalars
    typedef logic [`FLASH_AW-1:0] faddr_t;
    typedef logic [`FLASH_DW-1:0] fdata_t;
    typedef logic [7:0] wb_addr_t;
    typedef logic [31:0] wb_data_t;
    typedef logic [3:0] wb_sel_t;

    // Operations software may order
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_PROGRAM = 4'h1,
        OP_ERASE = 4'h2,
        OP_CLEAR = 4'h3,
        OP_READ_ARRAY = 4'h4,
        OP_READ_STATUS = 4'h5,
        OP_QUERY = 4'h6,
        OP_BUF_SETUP = 4'h7,
        OP_WRITE_RAW = 4'h8,
        OP_READ = 4'h9
    } op_e;

    // Sequencer states, Gray in listed order
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_FIRST = 3'h1,
        S_SECOND = 3'h3,
        S_POLL = 3'h2,
        S_READ = 3'h6,
        S_FINISH = 3'h7
    } seq_state_e;

    // Single bus cycle states
    typedef enum logic [1:0] {
        C_IDLE = 2'h0,
        C_ACTIVE = 2'h1,
        C_HOLD = 2'h3,
        C_GAP = 2'h2
    } cyc_state_e;

    // One flash bus cycle request
    typedef struct packed {
        logic we;
        faddr_t addr;
        fdata_t data;
    } req_s;

endpackage : flash_host_pkg

// [design/flash_bus_cycle.sv]
`timescale 1ns/1ps
`include "flash_host_cfg.svh"

module flash_bus_cycle #(
    parameter int ACC_CYC = `ACC_CYC,
    parameter int GAP_CYC = `REC_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input flash_host_pkg::req_s req_i,
    output logic done_o,
    output flash_host_pkg::fdata_t rdata_o,
    output logic ce_n_o,
    output logic oe_n_o,
    output logic we_n_o,
    output flash_host_pkg::faddr_t addr_o,
    output flash_host_pkg::fdata_t dq_o,
    output logic dq_oen_o,
    input flash_host_pkg::fdata_t dq_i
);
    import flash_host_pkg::*;

    cyc_state_e state_reg; // Cycle phase
    logic [7:0] cnt_reg; // Phase timer
    logic we_reg; // Direction of this cycle

    // One cycle: strobe low for the access time, then release and recover
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= C_IDLE;
            cnt_reg <= 8'h00;
            we_reg <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= '0;
            ce_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            we_n_o <= 1'b1;
            addr_o <= '0;
            dq_o <= '0;
            dq_oen_o <= 1'b1;
        end else begin
            done_o <= 1'b0;
            case (state_reg)
                // Wait for a request, then assert chip enable and strobe
                C_IDLE: begin
                    if (start_i) begin
                        we_reg <= req_i.we;
                        addr_o <= req_i.addr;
                        dq_o <= req_i.data;
                        dq_oen_o <= !req_i.we;
                        ce_n_o <= 1'b0;
                        oe_n_o <= req_i.we;
                        we_n_o <= !req_i.we;
                        cnt_reg <= 8'(ACC_CYC - 1);
                        state_reg <= C_ACTIVE;
                    end
                end
                // Strobe held low for the access time
                C_ACTIVE: begin
                    if (cnt_reg == 8'h00) begin
                        if (!we_reg) begin
                            rdata_o <= dq_i;
                        end
                        ce_n_o <= 1'b1;
                        oe_n_o <= 1'b1;
                        we_n_o <= 1'b1;
                        state_reg <= C_HOLD;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                // Data held one cycle past the strobe edge
                C_HOLD: begin
                    dq_oen_o <= 1'b1;
                    cnt_reg <= 8'(GAP_CYC - 1);
                    state_reg <= C_GAP;
                end
                // Recovery with all strobes high, so every read is a fresh toggle
                C_GAP: begin
                    if (cnt_reg == 8'h00) begin
                        done_o <= 1'b1;
                        state_reg <= C_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                default: begin
                    state_reg <= C_IDLE;
                end
            endcase
        end
    end

endmodule : flash_bus_cycle

// [design/flash_host_ctrl.sv]
// Operation
// - Status refreshes only on enable toggles
// - Never send status command after buffer setup
// - Program: setup code, then data, same address
// - Read-array command returns array output
// - Clear status before retry after error
// - Erase: setup code, then confirm code
// - Erase confirm immediately follows setup
//
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "flash_host_cfg.svh"

module flash_host_ctrl #(
    parameter int ACC_CYC = `ACC_CYC,
    parameter int GAP_CYC = `REC_CYC
) (
    input wire logic SYS_CLK_I,
    input wire logic RESETN_I,
    input flash_host_pkg::wb_addr_t WB_ADR_I,
    input flash_host_pkg::wb_data_t WB_DAT_I,
    output flash_host_pkg::wb_data_t WB_DAT_O,
    input wire logic WB_WE_I,
    input flash_host_pkg::wb_sel_t WB_SEL_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    output logic WB_ACK_O,
    output logic FLASH_CE_N_O,
    output logic FLASH_OE_N_O,
    output logic FLASH_WE_N_O,
    output flash_host_pkg::faddr_t FLASH_ADDR_O,
    output flash_host_pkg::fdata_t FLASH_DQ_O,
    output logic FLASH_DQ_OEN_O,
    input flash_host_pkg::fdata_t FLASH_DQ_I
);
    import flash_host_pkg::*;

    // Merge byte lanes of a bus write into a register
    function automatic wb_data_t wb_merge(input wb_data_t old, input wb_data_t nw,
                                          input wb_sel_t sel);
        wb_data_t res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction : wb_merge

    // Any error flag in a status byte
    function automatic logic sr_error(input logic [7:0] sr);
        return sr[`SR_PROG_FAIL_BIT] | sr[`SR_VOLT_BIT] | sr[`SR_LOCK_BIT];
    endfunction : sr_error

    wb_data_t addr_reg; // Target flash address
    wb_data_t data_reg; // Write data or raw word
    wb_data_t ctrl_reg; // Last order written
    fdata_t rdata_reg; // Data of the last single read from flash, not of status polls
    logic [7:0] sr_reg; // Last status byte seen
    logic err_seen_reg; // Error found, clear needed
    logic refused_reg; // An order was refused
    logic buf_pending_reg; // Buffer setup awaiting count word
    seq_state_e state_reg; // Sequencer state
    op_e op_reg; // Operation in progress
    logic issued_reg; // Bus cycle outstanding
    logic cyc_start_reg; // Bus cycle start pulse
    req_s req_reg; // Bus cycle request
    logic cyc_done; // Bus cycle finished
    fdata_t cyc_rdata; // Bus cycle read data
    logic bus_wr; // Write takes effect this edge
    op_e new_op; // Op field of the bus write
    logic ctrl_wr; // Order written this edge
    logic refuse; // Order must be refused
    logic go; // Order accepted

    assign bus_wr = WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I;
    assign new_op = op_e'(WB_DAT_I[`CTRL_OP_MSB:`CTRL_OP_LSB]);
    assign ctrl_wr = bus_wr && (WB_ADR_I == `REG_CTRL) && WB_SEL_I[0];
    // no status command in buffer phase
    assign refuse = (state_reg != S_IDLE)
        || (err_seen_reg && (new_op == OP_PROGRAM || new_op == OP_ERASE
                             || new_op == OP_BUF_SETUP))
        || (buf_pending_reg && new_op == OP_READ_STATUS);
    assign go = ctrl_wr && !refuse && (new_op != OP_NONE);

    // Wishbone slave: ack one cycle after request, read data registered
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= '0;
        end else begin
            WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
            WB_DAT_O <= '0;
            case (WB_ADR_I)
                `REG_CTRL: WB_DAT_O <= ctrl_reg;
                `REG_ADDR: WB_DAT_O <= addr_reg;
                `REG_DATA: WB_DAT_O <= data_reg;
                `REG_STATUS: begin
                    WB_DAT_O[`ST_BUSY_BIT] <= (state_reg != S_IDLE);
                    WB_DAT_O[`ST_REFUSED_BIT] <= refused_reg;
                    WB_DAT_O[`ST_ERR_BIT] <= err_seen_reg;
                    WB_DAT_O[`ST_BUFPEND_BIT] <= buf_pending_reg;
                    WB_DAT_O[`ST_SR_MSB:`ST_SR_LSB] <= sr_reg;
                end
                `REG_RDATA: WB_DAT_O <= 32'(rdata_reg);
                default: WB_DAT_O <= '0;
            endcase
        end
    end

    // Software-written registers
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            addr_reg <= '0;
            data_reg <= '0;
            ctrl_reg <= '0;
        end else if (bus_wr) begin
            case (WB_ADR_I)
                `REG_ADDR: addr_reg <= wb_merge(addr_reg, WB_DAT_I, WB_SEL_I);
                `REG_DATA: data_reg <= wb_merge(data_reg, WB_DAT_I, WB_SEL_I);
                `REG_CTRL: ctrl_reg <= wb_merge(ctrl_reg, WB_DAT_I, WB_SEL_I);
                default: ctrl_reg <= ctrl_reg;
            endcase
        end
    end

    // Refused flag: set on refusal, write one to clear, set wins
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            refused_reg <= 1'b0;
        end else if (ctrl_wr && refuse) begin
            refused_reg <= 1'b1;
        end else if (bus_wr && WB_ADR_I == `REG_STATUS && WB_SEL_I[0]
                     && WB_DAT_I[`ST_REFUSED_BIT]) begin
            refused_reg <= 1'b0;
        end
    end

    // Error and buffer-phase bookkeeping
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            err_seen_reg <= 1'b0;
            buf_pending_reg <= 1'b0;
        end else begin
            if (state_reg == S_FINISH && sr_error(sr_reg)
                && (op_reg == OP_PROGRAM || op_reg == OP_ERASE
                    || op_reg == OP_BUF_SETUP || op_reg == OP_READ_STATUS)) begin
                err_seen_reg <= 1'b1;
            end else if (state_reg == S_FINISH && op_reg == OP_CLEAR) begin
                err_seen_reg <= 1'b0;
            end
            // next written word is the count
            if (state_reg == S_FINISH && op_reg == OP_BUF_SETUP) begin
                buf_pending_reg <= 1'b1;
            end else if (go) begin
                buf_pending_reg <= 1'b0;
            end
        end
    end

    // Sequencer: issues flash bus cycles for one order
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state_reg <= S_IDLE;
            op_reg <= OP_NONE;
            issued_reg <= 1'b0;
            cyc_start_reg <= 1'b0;
            req_reg <= '0;
            sr_reg <= 8'h00;
            rdata_reg <= '0;
        end else begin
            cyc_start_reg <= 1'b0;
            case (state_reg)
                // Accept an order
                S_IDLE: begin
                    issued_reg <= 1'b0;
                    if (go) begin
                        op_reg <= new_op;
                        state_reg <= (new_op == OP_READ) ? S_READ : S_FIRST;
                    end
                end
                // First write: command code or raw word
                S_FIRST: begin
                    if (!issued_reg) begin
                        issued_reg <= 1'b1;
                        cyc_start_reg <= 1'b1;
                        req_reg.we <= 1'b1;
                        req_reg.addr <= addr_reg[`FLASH_AW-1:0];
                        case (op_reg)
                            OP_PROGRAM: req_reg.data <= `CMD_PROGRAM;
                            OP_ERASE: req_reg.data <= `CMD_ERASE_SETUP;
                            OP_CLEAR: req_reg.data <= `CMD_CLEAR_STATUS;
                            OP_READ_ARRAY: req_reg.data <= `CMD_READ_ARRAY;
                            OP_READ_STATUS: req_reg.data <= `CMD_READ_STATUS;
                            OP_QUERY: req_reg.data <= `CMD_QUERY;
                            OP_BUF_SETUP: req_reg.data <= `CMD_BUF_SETUP;
                            default: req_reg.data <= data_reg[`FLASH_DW-1:0];
                        endcase
                    end else if (cyc_done) begin
                        issued_reg <= 1'b0;
                        case (op_reg)
                            OP_PROGRAM, OP_ERASE: state_reg <= S_SECOND;
                            // status is output, poll without a command
                            OP_BUF_SETUP: state_reg <= S_POLL;
                            OP_READ_STATUS: state_reg <= S_READ;
                            default: state_reg <= S_FINISH;
                        endcase
                    end
                end
                // Second write: data or confirm, same address
                S_SECOND: begin
                    if (!issued_reg) begin
                        issued_reg <= 1'b1;
                        cyc_start_reg <= 1'b1;
                        req_reg.we <= 1'b1;
                        req_reg.data <= (op_reg == OP_PROGRAM) ? data_reg[`FLASH_DW-1:0]
                                                               : `CMD_CONFIRM;
                    end else if (cyc_done) begin
                        issued_reg <= 1'b0;
                        state_reg <= S_POLL;
                    end
                end
                // each poll is a fresh enable toggle
                S_POLL: begin
                    if (!issued_reg) begin
                        issued_reg <= 1'b1;
                        cyc_start_reg <= 1'b1;
                        req_reg.we <= 1'b0;
                    end else if (cyc_done) begin
                        issued_reg <= 1'b0;
                        sr_reg <= cyc_rdata[7:0];
                        if (cyc_rdata[`SR_READY_BIT]) begin
                            state_reg <= S_FINISH;
                        end
                    end
                end
                // Single read of array, query or status data
                S_READ: begin
                    if (!issued_reg) begin
                        issued_reg <= 1'b1;
                        cyc_start_reg <= 1'b1;
                        req_reg.we <= 1'b0;
                        req_reg.addr <= addr_reg[`FLASH_AW-1:0];
                    end else if (cyc_done) begin
                        issued_reg <= 1'b0;
                        rdata_reg <= cyc_rdata;
                        if (op_reg == OP_READ_STATUS) begin
                            sr_reg <= cyc_rdata[7:0];
                        end
                        state_reg <= S_FINISH;
                    end
                end
                // Settle flags, then idle
                S_FINISH: begin
                    state_reg <= S_IDLE;
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // Pin timing engine
    flash_bus_cycle #(
        .ACC_CYC(ACC_CYC),
        .GAP_CYC(GAP_CYC)
    ) u_cycle (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RESETN_I),
        .start_i(cyc_start_reg),
        .req_i(req_reg),
        .done_o(cyc_done),
        .rdata_o(cyc_rdata),
        .ce_n_o(FLASH_CE_N_O),
        .oe_n_o(FLASH_OE_N_O),
        .we_n_o(FLASH_WE_N_O),
        .addr_o(FLASH_ADDR_O),
        .dq_o(FLASH_DQ_O),
        .dq_oen_o(FLASH_DQ_OEN_O),
        .dq_i(FLASH_DQ_I)
    );

    // Checks
    property p_poll_toggle;
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        (state_reg == S_POLL && cyc_start_reg) |=> !FLASH_OE_N_O ##[1:300] FLASH_OE_N_O;
    endproperty
    a_poll_toggle: assert property (p_poll_toggle) else $error("poll without OE toggle");
    property p_no_status_cmd;
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        buf_pending_reg |-> !(ctrl_wr && !refuse && new_op == OP_READ_STATUS);
    endproperty
    a_no_status_cmd: assert property (p_no_status_cmd) else $error("status cmd in buffer");
    property p_prog_pair;
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        (state_reg == S_SECOND && op_reg == OP_PROGRAM && cyc_start_reg)
        |-> req_reg.we && req_reg.data == data_reg[`FLASH_DW-1:0]
            && req_reg.addr == addr_reg[`FLASH_AW-1:0];
    endproperty
    a_prog_pair: assert property (p_prog_pair) else $error("program data mismatch");
    property p_read_array;
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        (go && new_op == OP_READ_ARRAY) |=> ##1 (req_reg.data == `CMD_READ_ARRAY && cyc_start_reg);
    endproperty
    a_read_array: assert property (p_read_array) else $error("read array code wrong");
    property p_err_block;
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        err_seen_reg |-> !(go && new_op == OP_PROGRAM);
    endproperty
    a_err_block: assert property (p_err_block) else $error("program after error");
    property p_erase_confirm;
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        (state_reg == S_SECOND && op_reg == OP_ERASE && cyc_start_reg)
        |-> req_reg.data == `CMD_CONFIRM && $past(state_reg, 2) == S_FIRST;
    endproperty
    a_erase_confirm: assert property (p_erase_confirm) else $error("bad erase confirm");
    property p_erase_next;
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        (cyc_done && state_reg == S_FIRST && op_reg == OP_ERASE) |=> state_reg == S_SECOND;
    endproperty
    a_erase_next: assert property (p_erase_next) else $error("erase confirm delayed");
    property p_ack_pulse;
        @(posedge SYS_CLK_I) disable iff (!RESETN_I)
        WB_ACK_O |=> !WB_ACK_O;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");
    c_program: cover property (@(posedge SYS_CLK_I) state_reg == S_FINISH && op_reg == OP_PROGRAM);
    c_erase: cover property (@(posedge SYS_CLK_I) state_reg == S_FINISH && op_reg == OP_ERASE);
    c_refused: cover property (@(posedge SYS_CLK_I) ctrl_wr && refuse);
    c_query: cover property (@(posedge SYS_CLK_I) state_reg == S_FINISH && op_reg == OP_QUERY);

endmodule : flash_host_ctrl

// [verif/flash_dev_model.sv]
`timescale 1ns/1ps
module flash_dev_model (
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input flash_host_pkg::faddr_t addr_i,
    input flash_host_pkg::fdata_t dq_i,
    output flash_host_pkg::fdata_t dq_o
);
    import flash_host_pkg::*;
    fdata_t mem [16];
    logic [1:0] mode = 2'h0; // Array, status or query output
    logic [1:0] pend = 2'h0; // Program, erase or buffer count awaited
    logic [7:0] err = 8'h00;
    int busy = 0;
    fdata_t out = 16'h0000;
    // Command decode on the write strobe
    // Second write of pair
    always @(posedge we_n_i) begin
        if (pend != 2'h0) begin
            if (pend == 2'h1) begin
                mem[addr_i[3:0]] = dq_i;
            end
            if (pend == 2'h1 || (pend == 2'h2 && dq_i[7:0] == 8'hD0)) begin
                err = err | {3'h0, addr_i[23], addr_i[22], 1'b0, addr_i[23], 1'b0};
                busy = 2;
                mode = 2'h1;
            end
            pend = 2'h0;
        end else begin
            case (dq_i[7:0])
                8'h40: pend = 2'h1;
                8'h20: pend = 2'h2;
                8'hE8: begin
                    pend = 2'h3;
                    mode = 2'h1;
                end
                8'h50: err = 8'h00;
                8'hFF: mode = 2'h0;
                8'h70: mode = 2'h1;
                8'h98: mode = 2'h2;
                default: ;
            endcase
        end
    end
    always @(negedge oe_n_i or negedge ce_n_i) begin
        if (busy > 0) begin
            busy = busy - 1;
        end
        case (mode)
            2'h0: out = mem[addr_i[3:0]];
            2'h1: out = {8'h00, busy == 0, err[6:0]};
            default: begin
                case (addr_i[7:0])
                    8'h10: out = 16'h0051;
                    8'h11: out = 16'h0052;
                    8'h12: out = 16'h0059;
                    8'h13: out = 16'h0001;
                    8'h15: out = 16'h0031;
                    default: out = 16'h0000;
                endcase
            end
        endcase
    end
    // Released bus shows the inverse, not stale data
    always @(posedge oe_n_i) begin
        out = ~out;
    end
    assign dq_o = out;
endmodule : flash_dev_model

// [verif/flash_host_ctrl_test.sv]
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module flash_host_ctrl_test;
    import flash_host_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    wb_addr_t adr = 8'h00;
    wb_data_t wdat = 32'h0;
    wb_data_t rdat;
    wb_data_t q;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic ack, ce_n, oe_n, we_n, dq_oen;
    faddr_t faddr;
    fdata_t fdq_o, fdq_i;
    int n_errors = 0;
    int n_tests = 0;
    wb_data_t qexp [6] = '{32'h51, 32'h52, 32'h59, 32'h01, 32'h00, 32'h31};
    always #4 sys_clk = ~sys_clk;
    flash_host_ctrl #(.ACC_CYC(2), .GAP_CYC(1)) dut (.SYS_CLK_I(sys_clk), .RESETN_I(resetn),
        .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_WE_I(we), .WB_SEL_I(4'hF),
        .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_ACK_O(ack), .FLASH_CE_N_O(ce_n),
        .FLASH_OE_N_O(oe_n), .FLASH_WE_N_O(we_n), .FLASH_ADDR_O(faddr), .FLASH_DQ_O(fdq_o),
        .FLASH_DQ_OEN_O(dq_oen), .FLASH_DQ_I(fdq_i));
    flash_dev_model dev (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(faddr),
        .dq_i(fdq_o), .dq_o(fdq_i));
    // Drive enable must follow direction while the chip is selected
    always @(posedge sys_clk) begin
        if (resetn && ce_n === 1'b0 && dq_oen !== ~oe_n) begin
            $display("BAD t=%0t oen=%h exp=%h", $time, dq_oen, ~oe_n);
            n_errors++;
        end
    end
    // Classic single Wishbone cycle, read data lands in q
    task automatic wb(input wb_addr_t a, input wb_data_t d, input logic w);
        int n;
        n = 0;
        @(posedge sys_clk);
        cyc <= 1'b1;
        adr <= a;
        wdat <= d;
        we <= w;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        // A missing acknowledge counts as a mismatch
        if (ack !== 1'b1) begin
            chk({31'h0, ack}, 32'h1);
        end
        q = rdat;
        cyc <= 1'b0;
        we <= 1'b0;
    endtask : wb
    task automatic chk(input wb_data_t g, input wb_data_t e);
        n_tests++;
        if (g !== e) begin
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
            n_errors++;
        end
    endtask : chk
    // Order one operation and poll until not busy
    task automatic op(input op_e o, input faddr_t a, input fdata_t d);
        int n;
        n = 0;
        wb(`REG_ADDR, {8'h00, a}, 1'b1);
        wb(`REG_DATA, {16'h0, d}, 1'b1);
        wb(`REG_CTRL, {28'h0, o}, 1'b1);
        do begin
            wb(`REG_STATUS, 32'h0, 1'b0);
            n++;
        end while (q[0] !== 1'b0 && n < 200);
        // An order that never finishes counts as a mismatch
        if (q[0] !== 1'b0) begin
            chk({31'h0, q[0]}, 32'h0);
        end
    endtask : op
    task automatic rd(input faddr_t a, input wb_data_t e);
        op(OP_READ, a, 16'h0);
        wb(`REG_RDATA, 32'h0, 1'b0);
        chk(q, e);
    endtask : rd
    task automatic finish_test;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        wb(`REG_STATUS, 32'h0, 1'b0);
        chk(q, 32'h0);
        wb(8'h40, 32'h0, 1'b0);
        chk(q, 32'h0);
        op(OP_PROGRAM, 24'h000003, 16'h1234);
        chk(q, 32'h8000);
        op(OP_PROGRAM, 24'h400002, 16'h0001);
        chk(q, 32'h8804);
        op(OP_PROGRAM, 24'h000005, 16'h0002);
        chk(q, 32'h8806);
        wb(`REG_STATUS, 32'h2, 1'b1);
        op(OP_CLEAR, 24'h0, 16'h0);
        op(OP_PROGRAM, 24'h800001, 16'h0003);
        chk(q, 32'h9204);
        op(OP_CLEAR, 24'h0, 16'h0);
        op(OP_ERASE, 24'h0, 16'h0);
        chk(q, 32'h8000);
        op(OP_READ_ARRAY, 24'h0, 16'h0);
        rd(24'h000003, 32'h1234);
        op(OP_QUERY, 24'h0, 16'h0);
        for (int i = 0; i < 6; i++) begin
            rd(faddr_t'(16 + i), qexp[i]);
        end
        op(OP_READ_ARRAY, 24'h0, 16'h0);
        rd(24'h000003, 32'h1234);
        op(OP_BUF_SETUP, 24'h0, 16'h0);
        chk(q, 32'h8008);
        op(OP_READ_STATUS, 24'h0, 16'h0);
        chk(q, 32'h800A);
        wb(`REG_STATUS, 32'h2, 1'b1);
        op(OP_WRITE_RAW, 24'h0, 16'h0);
        chk(q, 32'h8000);
        finish_test();
    end
    // Watchdog against a hung handshake
    initial begin
        #200000;
        n_errors++;
        finish_test();
    end
endmodule : flash_host_ctrl_test
